// ---- rtl/lgtg_pkg.sv ----
// Shared constants for the LED grouping, threshold and output select block
package lgtg_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_GROUP_HIGH     = 8'h08;
    localparam logic [7:0] ADDR_GROUP_LOW      = 8'h09;
    localparam logic [7:0] ADDR_THRESH_FIRST   = 8'h0A;
    localparam logic [7:0] ADDR_THRESH_LAST    = 8'h0E;
    localparam logic [7:0] ADDR_OUTPUT_SELECT  = 8'h0F;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int GROUP_HIGH_BIT   = 0;
    localparam int THRESH_ODD_LSB   = 0;
    localparam int THRESH_EVEN_LSB  = 4;
    localparam int THRESH_W         = 3;
    localparam int SEL_ONE_LSB      = 3;
    localparam int SEL_TWO_LSB      = 0;
    localparam int SEL_W            = 2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] GROUP_LOW_RESET   = 8'h00;
    localparam logic       GROUP_HIGH_RESET  = 1'b0;
    localparam logic [2:0] THRESH_RESET      = 3'h0;
    localparam logic [1:0] SEL_RESET         = 2'h0;

    // ------------------------------------------------------------
    // Analog scaling and timing
    // ------------------------------------------------------------
    localparam logic [3:0] THRESH_BASE_VOLTS = 4'hC;
    localparam int ON_TIME_W        = 16;
    localparam int ON_TIME_STEP_NS  = 150;
    localparam int CLK_PERIOD_NS    = 100;
    localparam int MARK_LOW_NS      = 300;
    localparam int MARK_LOW_RAW     = MARK_LOW_NS / CLK_PERIOD_NS;
    localparam int MARK_LOW_CYC     = (MARK_LOW_RAW < 1) ? 1 : MARK_LOW_RAW;

    // ------------------------------------------------------------
    // Output pin sources
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        PIN1_SOFT_START = 2'b00,
        PIN1_CLK_DIV4   = 2'b01,
        PIN1_PWM_MARK   = 2'b10,
        PIN1_THERMAL    = 2'b11
    } lgtg_pin1_t;

    typedef enum logic [1:0] {
        PIN2_STARTUP    = 2'b00,
        PIN2_CUR_LIMIT  = 2'b01,
        PIN2_BOOST_SW   = 2'b10,
        PIN2_RESERVED   = 2'b11
    } lgtg_pin2_t;

endpackage : lgtg_pkg

// ---- rtl/lgtg_regs.sv ----
// Grouping, short-detect threshold and output pin select registers
`timescale 1ns/1ns

// How it works
// - Bit 0 at 0x08 groups channel 10
// - Byte 0x09 bit n groups channel n+2
// - Ungrouped channel uses own slot, own on-time
// - Grouped channel follows lower neighbour slot, on-time
// - Chains take lowest member's slot and on-time
// - Channel 2 bit joins channel 1
// - 0x0A-0x0E hold odd/even 3-bit threshold codes
// - Code steps 1 V, 000 is 12 V
// - Each channel gets its own threshold
// - Pin one select 00 shows soft start
// - Pin one select 01 gives clock divided four
// - Pin one select 10 pulses low per period
// - Pin one select 11 low during thermal derating
// - Pin two select 00 high until test passes
// - Pin two select 01 low on current limit
// - Pin two select 10 high while boost switches
// - Duty cycle from 16-bit 150 ns on-time
module lgtg_regs
    import lgtg_pkg::*;
#(
    parameter int CHANNELS = 10
) (
    // Clock, reset, enable
    input  wire logic                          sys_clk,
    input  wire logic                          sys_rst,
    input  wire logic                          clk_en,
    // Register access from the serial interface decoder
    input  wire logic                          reg_wr,
    input  wire logic                          reg_rd,
    input  wire logic [7:0]                    reg_addr,
    input  wire logic [7:0]                    reg_wdata,
    output logic      [7:0]                    reg_rdata,
    output logic                               reg_hit,
    // Per-channel slot starts and programmed on-times
    input  wire logic [CHANNELS-1:0]           slot_start,
    input  wire logic [CHANNELS*ON_TIME_W-1:0] on_time_high_byte_in,
    // Per-channel effective timing
    output logic      [CHANNELS-1:0]           chan_start,
    output logic      [CHANNELS*ON_TIME_W-1:0] chan_on_time,
    // Per-channel short detection setup
    output logic      [CHANNELS*THRESH_W-1:0]  short_threshold_code,
    output logic      [CHANNELS*4-1:0]         short_threshold_volts,
    // Core status feeding the output pins
    input  wire logic                          soft_start_active,
    input  wire logic                          pwm_period_start,
    input  wire logic                          thermal_derate_active,
    input  wire logic                          startup_test_passed,
    input  wire logic                          current_limit_hit,
    input  wire logic                          boost_switching,
    // General purpose output pins
    output logic                               output_pin_one,
    output logic                               output_pin_two
);

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    localparam int PAIRS = CHANNELS / 2;

    logic [7:0]          channel_group_low;
    logic                channel_group_high;
    logic [THRESH_W-1:0] thresh_odd  [0:PAIRS-1];
    logic [THRESH_W-1:0] thresh_even [0:PAIRS-1];
    logic [SEL_W-1:0]    output_pin_one_select;
    logic [SEL_W-1:0]    output_pin_two_select;

    // ------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------
    wire       hit_group_high = (reg_addr == ADDR_GROUP_HIGH);
    wire       hit_group_low  = (reg_addr == ADDR_GROUP_LOW);
    wire       hit_thresh     = (reg_addr >= ADDR_THRESH_FIRST) &&
                                (reg_addr <= ADDR_THRESH_LAST);
    wire       hit_select     = (reg_addr == ADDR_OUTPUT_SELECT);
    wire [7:0] thresh_off     = reg_addr - ADDR_THRESH_FIRST;
    wire [2:0] thresh_idx     = thresh_off[2:0];
    wire       addr_hit       = hit_group_high | hit_group_low |
                                hit_thresh | hit_select;

    logic [7:0] next_rdata;
    always_comb begin
        next_rdata = 8'h00;
        if (hit_group_high) begin
            next_rdata[GROUP_HIGH_BIT] = channel_group_high;
        end else if (hit_group_low) begin
            next_rdata = channel_group_low;
        end else if (hit_thresh) begin
            next_rdata[THRESH_ODD_LSB +: THRESH_W]  = thresh_odd[thresh_idx];
            next_rdata[THRESH_EVEN_LSB +: THRESH_W] = thresh_even[thresh_idx];
        end else if (hit_select) begin
            next_rdata[SEL_ONE_LSB +: SEL_W] = output_pin_one_select;
            next_rdata[SEL_TWO_LSB +: SEL_W] = output_pin_two_select;
        end
    end

    // ------------------------------------------------------------
    // Register writes and read data
    // ------------------------------------------------------------
    // Unused bits are never stored, so they always read back as zero
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            channel_group_high    <= GROUP_HIGH_RESET;
            channel_group_low     <= GROUP_LOW_RESET;
            output_pin_one_select <= SEL_RESET;
            output_pin_two_select <= SEL_RESET;
            reg_rdata             <= 8'h00;
            reg_hit               <= 1'b0;
        end else if (clk_en) begin
            if (reg_wr && hit_group_high) begin
                channel_group_high <= reg_wdata[GROUP_HIGH_BIT];
            end
            if (reg_wr && hit_group_low) begin
                channel_group_low <= reg_wdata;
            end
            if (reg_wr && hit_select) begin
                output_pin_one_select <= reg_wdata[SEL_ONE_LSB +: SEL_W];
                output_pin_two_select <= reg_wdata[SEL_TWO_LSB +: SEL_W];
            end
            if (reg_rd) begin
                reg_rdata <= next_rdata;
                reg_hit   <= addr_hit;
            end
        end
    end

    genvar p;
    generate
        for (p = 0; p < PAIRS; p++) begin : g_thresh
            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    thresh_odd[p]  <= THRESH_RESET;
                    thresh_even[p] <= THRESH_RESET;
                end else if (clk_en && reg_wr && hit_thresh &&
                             thresh_idx == 3'(p)) begin
                    // Odd channel low field, even channel high field
                    thresh_odd[p]  <= reg_wdata[THRESH_ODD_LSB +: THRESH_W];
                    thresh_even[p] <= reg_wdata[THRESH_EVEN_LSB +: THRESH_W];
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Channel grouping
    // ------------------------------------------------------------
    // Index 0 is channel 1, which can never follow anyone
    wire [CHANNELS-1:0] grouped = {channel_group_high, channel_group_low,
                                   1'b0};

    logic [3:0] src [0:CHANNELS-1];

    genvar c;
    generate
        for (c = 0; c < CHANNELS; c++) begin : g_chan
            // Walking down the chain lands on its lowest member
            if (c == 0) begin : g_first
                assign src[c] = 4'h0;
            end else begin : g_rest
                assign src[c] = grouped[c] ? src[c-1] : 4'(c);
            end

            wire [ON_TIME_W-1:0] own_time =
                on_time_high_byte_in[src[c]*ON_TIME_W +: ON_TIME_W];
            wire [THRESH_W-1:0]  code = (c % 2 == 0) ? thresh_odd[c/2]
                                                       : thresh_even[c/2];

            always_ff @(posedge sys_clk) begin
                if (sys_rst) begin
                    chan_start[c] <= 1'b0;
                    chan_on_time[c*ON_TIME_W +: ON_TIME_W] <= '0;
                    short_threshold_code[c*THRESH_W +: THRESH_W] <= '0;
                    short_threshold_volts[c*4 +: 4] <= THRESH_BASE_VOLTS;
                end else if (clk_en) begin
                    // Own slot is dropped once grouped
                    chan_start[c] <= slot_start[src[c]];
                    chan_on_time[c*ON_TIME_W +: ON_TIME_W] <= own_time;
                    short_threshold_code[c*THRESH_W +: THRESH_W] <= code;
                    short_threshold_volts[c*4 +: 4] <=
                        THRESH_BASE_VOLTS - {1'b0, code};
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Output pin sources
    // ------------------------------------------------------------
    localparam int MARK_W = $clog2(MARK_LOW_CYC + 1);

    logic [1:0]        clk_div;
    logic [MARK_W-1:0] mark_cnt;

    wire mark_low = (mark_cnt != '0);

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            clk_div  <= 2'h0;
            mark_cnt <= '0;
        end else if (clk_en) begin
            clk_div <= clk_div + 2'h1;
            if (pwm_period_start) begin
                mark_cnt <= MARK_W'(MARK_LOW_CYC);
            end else if (mark_low) begin
                mark_cnt <= mark_cnt - 1'b1;
            end
        end
    end

    lgtg_pin1_t pin1_sel;
    lgtg_pin2_t pin2_sel;
    assign pin1_sel = lgtg_pin1_t'(output_pin_one_select);
    assign pin2_sel = lgtg_pin2_t'(output_pin_two_select);

    logic next_pin_one;
    logic next_pin_two;

    always_comb begin
        case (pin1_sel)
            PIN1_SOFT_START: next_pin_one = soft_start_active;
            PIN1_CLK_DIV4:   next_pin_one = clk_div[1];
            PIN1_PWM_MARK:   next_pin_one = ~mark_low;
            PIN1_THERMAL:    next_pin_one = ~thermal_derate_active;
            default:         next_pin_one = soft_start_active;
        endcase
    end

    always_comb begin
        case (pin2_sel)
            PIN2_STARTUP:   next_pin_two = ~startup_test_passed;
            PIN2_CUR_LIMIT: next_pin_two = ~current_limit_hit;
            PIN2_BOOST_SW:  next_pin_two = boost_switching;
            // Reserved code parks the pin at its idle level
            default:        next_pin_two = 1'b1;
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            output_pin_one <= 1'b0;
            output_pin_two <= 1'b1;
        end else if (clk_en) begin
            output_pin_one <= next_pin_one;
            output_pin_two <= next_pin_two;
        end
    end

endmodule : lgtg_regs

// ---- tb/lgtg_host.sv ----
// Register host model driving the parallel register strobe port
`timescale 1ns/1ns
module lgtg_host (
    // Clock
    input  wire logic       sys_clk,
    // Register strobe port
    output logic            reg_wr,
    output logic            reg_rd,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata
);
    initial {reg_wr, reg_rd, reg_addr, reg_wdata} = 18'h00000;
    // Released lines show inverted values so stale data never matches
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1 d = reg_rdata;
    endtask : rd
endmodule : lgtg_host

// ---- tb/lgtg_props.sv ----
// Port checker for the grouping, threshold and pin select block
`timescale 1ns/1ns
module lgtg_props #(
    parameter int CHANNELS = 10
) (
    // Clock and reset
    input wire logic                sys_clk,
    input wire logic                sys_rst,
    input wire logic                clk_en,
    // Register port
    input wire logic                reg_wr,
    input wire logic                reg_rd,
    input wire logic [7:0]          reg_addr,
    input wire logic [7:0]          reg_wdata,
    input wire logic [7:0]          reg_rdata,
    input wire logic                reg_hit,
    // Channels, status and pins
    input wire logic [CHANNELS-1:0] slot_start,
    input wire logic [CHANNELS-1:0] chan_start,
    input wire logic                soft_start_active,
    input wire logic                pwm_period_start,
    input wire logic                startup_test_passed,
    input wire logic                output_pin_one,
    input wire logic                output_pin_two
);
    // Shadows track the select and group bytes so pin and grouping checks know the active setting
    logic [7:0] sel_q;
    logic [7:0] grp_q;
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sel_q <= 8'h00;
            grp_q <= 8'h00;
        end else if (clk_en && reg_wr) begin
            if (reg_addr == 8'h0F) sel_q <= reg_wdata;
            if (reg_addr == 8'h09) grp_q <= reg_wdata;
        end
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst || !clk_en);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    sequence s_mark_go;
        sel_q[4:3] == 2'b10 && pwm_period_start;
    endsequence
    sequence s_mark_low;
        (!output_pin_one) [*3];
    endsequence
    property p_rd_group;
        reg_rd && reg_addr == 8'h08 |=> reg_hit && reg_rdata[7:1] == 7'h00;
    endproperty
    a_rd_group: assert property (p_rd_group) else $error("group read");
    property p_pin1_soft;
        sel_q[4:3] == 2'b00 |=> output_pin_one == $past(soft_start_active);
    endproperty
    a_pin1_soft: assert property (p_pin1_soft) else $error("pin one");
    property p_pin1_div;
        (sel_q[4:3] == 2'b01) [*4] |-> output_pin_one != $past(output_pin_one, 2);
    endproperty
    a_pin1_div: assert property (p_pin1_div) else $error("divider");
    property p_pin1_mark;
        s_mark_go |-> ##2 s_mark_low;
    endproperty
    a_pin1_mark: assert property (p_pin1_mark) else $error("marker");
    property p_pin2_start;
        sel_q[1:0] == 2'b00 |=> output_pin_two == !$past(startup_test_passed);
    endproperty
    a_pin2_start: assert property (p_pin2_start) else $error("pin two");
    property p_pin2_res;
        sel_q[1:0] == 2'b11 |=> output_pin_two;
    endproperty
    a_pin2_res: assert property (p_pin2_res) else $error("reserved");
    property p_grp_one;
        grp_q[0] |=> chan_start[1] == $past(slot_start[0]);
    endproperty
    a_grp_one: assert property (p_grp_one) else $error("chan two");
    property p_grp_chain;
        grp_q[5:3] == 3'b110 |=> chan_start[6] == $past(slot_start[4]);
    endproperty
    a_grp_chain: assert property (p_grp_chain) else $error("chain");
endmodule : lgtg_props

// ---- tb/lgtg_regs_test.sv ----
// Self-checking bench for the grouping, threshold and pin select block
`timescale 1ns/1ns
module lgtg_regs_test;
    localparam logic [8:0] GRP = 9'h131;
    logic         sys_clk = 1'b0;
    logic         sys_rst = 1'b1;
    logic         clk_en = 1'b1;
    logic         reg_wr, reg_rd, reg_hit, pin1, pin2;
    logic [7:0]   reg_addr, reg_wdata, reg_rdata, rv, a;
    logic [9:0]   slot_start = 10'h000;
    logic [9:0]   chan_start, exp_start;
    logic [159:0] on_time, chan_on_time;
    logic [29:0]  codes;
    logic [39:0]  volts;
    logic [4:0]   st = 5'h00;
    logic         pwm = 1'b0;
    int           error_cnt = 0;
    int           samples_checked = 0;
    int           cyc = 0;
    int           n;
    lgtg_host i_host (.sys_clk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata,
        .reg_rdata);
    lgtg_regs #(.CHANNELS(10)) i_dut (.sys_clk, .sys_rst, .clk_en, .reg_wr,
        .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_hit, .slot_start,
        .on_time_high_byte_in(on_time), .chan_start, .chan_on_time,
        .short_threshold_code(codes), .short_threshold_volts(volts),
        .soft_start_active(st[4]), .pwm_period_start(pwm),
        .thermal_derate_active(st[3]), .startup_test_passed(st[2]),
        .current_limit_hit(st[1]), .boost_switching(st[0]),
        .output_pin_one(pin1), .output_pin_two(pin2));
    initial forever #50 sys_clk = ~sys_clk;
    // Under two hundred cycles expected; ceiling leaves ample margin
    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 3000) begin
            error_cnt++;
            close_out();
        end
    end
    task automatic chk(input string nm, input logic [15:0] e, g);
        samples_checked++;
        if (g !== e) begin
            error_cnt++;
            $display("BAD %s exp %h got %h", nm, e, g);
        end
    endtask : chk
    task automatic chk_bit(input string nm, input logic e, g);
        chk(nm, {15'h0000, e}, {15'h0000, g});
    endtask : chk_bit
    task automatic close_out();
        $display("checks %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : close_out
    function automatic int root(input int j);
        while (j > 0 && GRP[j-1]) j--;
        return j;
    endfunction : root
    function automatic logic [7:0] rmask(input logic [7:0] ad);
        if (ad == 8'h08) return 8'h01;
        if (ad == 8'h09) return 8'hFF;
        if (ad == 8'h0F) return 8'h1B;
        return (ad inside {[8'h0A:8'h0E]}) ? 8'h77 : 8'h00;
    endfunction : rmask
    initial begin
        for (int k = 0; k < 10; k++) on_time[16*k +: 16] = 16'h1000 + 16'(k);
        repeat (12) @(posedge sys_clk);
        sys_rst <= 1'b0;
        for (a = 8'h07; a <= 8'h10; a++) begin
            i_host.rd(a, rv);
            chk("reset", 16'h0000, {8'h00, rv});
            chk_bit("hit", a inside {[8'h08:8'h0F]}, reg_hit);
            i_host.wr(a, 8'hFF);
            i_host.rd(a, rv);
            chk("rw", {8'h00, rmask(a)}, {8'h00, rv});
        end
        $display("access test done");
        for (int i = 0; i < 5; i++)
            i_host.wr(8'h0A + 8'(i), {1'b0, 3'(2*i+1), 1'b0, 3'(2*i)});
        @(posedge sys_clk);
        #1;
        for (int k = 0; k < 10; k++) begin
            chk("code", 16'(k & 7), {13'h0000, codes[3*k +: 3]});
            chk("volts", 16'(12 - (k & 7)), {12'h000, volts[4*k +: 4]});
        end
        $display("threshold test done");
        i_host.wr(8'h09, 8'h31);
        i_host.wr(8'h08, 8'h01);
        for (int k = 0; k < 10; k++) begin
            for (int j = 0; j < 10; j++) exp_start[j] = (root(j) == k);
            @(posedge sys_clk);
            slot_start <= 10'(1 << k);
            @(posedge sys_clk);
            slot_start <= 10'h000;
            #1 chk("start", {6'h00, exp_start}, {6'h00, chan_start});
            chk("on time", 16'h1000 + 16'(root(k)), chan_on_time[16*k +: 16]);
        end
        $display("grouping test done");
        // Enable low must hold every stage, so a slot pulse is lost
        @(posedge sys_clk);
        clk_en <= 1'b0;
        slot_start <= 10'h004;
        repeat (2) @(posedge sys_clk);
        clk_en <= 1'b1;
        slot_start <= 10'h000;
        #1 chk("frozen", 16'h0000, {6'h00, chan_start});
        $display("freeze test done");
        for (int c = 0; c < 4; c++) begin
            i_host.wr(8'h0F, {3'h0, 2'(c), 1'b0, 2'(c)});
            for (int v = 0; v < 2; v++) begin
                @(posedge sys_clk);
                st <= {5{v[0]}};
                repeat (2) @(posedge sys_clk);
                #1;
                if (c == 0) chk_bit("soft", v[0], pin1);
                if (c == 3) chk_bit("thermal", !v[0], pin1);
                chk_bit("pin two", (c == 3) || ((c == 2) ~^ v[0]), pin2);
            end
            n = 0;
            if (c == 2) begin
                chk_bit("idle mark", 1'b1, pin1);
                @(posedge sys_clk);
                pwm <= 1'b1;
                @(posedge sys_clk);
                pwm <= 1'b0;
            end
            repeat (8) begin
                @(posedge sys_clk);
                #1 n += int'(pin1 === 1'b0);
            end
            if (c == 1) chk("div lows", 16'd4, 16'(n));
            if (c == 2) chk("mark lows", 16'd3, 16'(n));
        end
        $display("pin test done");
        close_out();
    end
endmodule : lgtg_regs_test
bind lgtg_regs lgtg_props #(.CHANNELS(CHANNELS)) u_props (.sys_clk, .sys_rst,
    .clk_en, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_hit,
    .slot_start, .chan_start, .soft_start_active, .pwm_period_start,
    .startup_test_passed, .output_pin_one, .output_pin_two);
